// ---- core/eeprom_defs.svh ----
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Core clock rate
`define CLK_MHZ 100
// Longest programming time, in microseconds
`define WRITE_TIME_US 5000
// Longest time in whole core cycles, exact product of time and clock rate
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
// Stable-cycle count of the line glitch filter
`define FILT_CYCLES 2
// Array and page geometry
`define ARRAY_AW 15
`define PAGE_AW 6
`define PAGE_BYTES 64
`define BYTE_W 8
// Bit count value of the ninth clock
`define ACK_BIT 4'h8
// Erased array contents
`define ERASED_BYTE 8'hFF

`endif

// ---- core/eeprom_pkg.sv ----
package eeprom_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_WDATA,
      ST_RDATA,
      ST_PROG
   } state_t;

endpackage : eeprom_pkg

// ---- core/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 2,
   parameter int FILT = 2
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] pin_o
);

   localparam int CW = $clog2(FILT + 1);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] last_q;
   logic [CW-1:0] cnt_q;
   logic stable;

   // With FILT above 1, output follows only a level held FILT+1 cycles; shorter spikes are lost
   assign stable = (sync_q == last_q) && (cnt_q == CW'(FILT - 1));

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= '1;
         sync_q <= '1;
         last_q <= '1;
         cnt_q <= '0;
         pin_o <= '1;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
         if (sync_q != last_q) begin
            cnt_q <= '0;
         end else if (!stable) begin
            cnt_q <= cnt_q + CW'(1);
         end
         if (stable || FILT == 1) begin
            pin_o <= last_q;
         end
      end
   end

endmodule : pin_sync

`default_nettype wire

// ---- core/eeprom_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "eeprom_defs.svh"

module eeprom_mem #(
   parameter int AW = 15,
   parameter int DW = 8
) (
   input wire logic core_clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Delivered parts read as erased
   initial begin
      for (int i = 0; i < (1 << AW); i++) begin
         mem[i] = DW'(`ERASED_BYTE);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule : eeprom_mem

`default_nettype wire

// ---- core/eeprom_slave.sv ----
// Notes on behaviour
// - Sample data on serial clock rise, change output data after its fall.
// - Data line is open drain: only pulled low or released.
// - Data changes only while clock is low, except start and stop.
// - Respond only when received select code equals the three select pins.
// - An unconnected select pin counts as low.
// - Start is data falling with clock high; it begins every transfer.
// - Stop is data rising with clock high; after a read, go idle.
// - Stop after write data ends input and starts a timed programming cycle.
// - Bytes are eight bits; receiver pulls low on the ninth clock.
// - Release after each read byte; zero ack sends next address byte.
// - Without zero ack or stop, stay released and send nothing more.
// - First byte is the address word; upper four bits are the type code.
// - Select bits follow high, mid, low; direction is the eighth bit.
// - Direction low starts a write, high starts a read.
// - Match: ack then operate; mismatch: no ack and back to idle.
// - Write: two address bytes then data, each acked when permitted.
// - During programming, clock and data inputs are ignored.
// - Up to 64 data bytes are programmed together when stop arrives.
// - Only the six in-page offset bits advance and wrap within the page.
// - Protect pin high: ack addresses, no ack on data, no programming.
// - Protect pin low permits writes; reads work regardless of it.
// - Programming lasts no longer than 5 ms from the stop.
// - While programming, address words get no ack; afterwards they do.
`timescale 1ns/100ps
`default_nettype none

`include "eeprom_defs.svh"

module eeprom_slave #(
   parameter logic [3:0] DEV_TYPE = 4'h5, // Arbitrary type code
   parameter int WRITE_CYCLES = `WRITE_CYCLES,
   parameter int FILT_CYCLES = `FILT_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic select_pin_high_i,
   input wire logic select_pin_mid_i,
   input wire logic select_pin_low_i,
   input wire logic wp_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic prog_busy_o,
   output eeprom_pkg::state_t state_o
);
   import eeprom_pkg::*;

   localparam int AW = `ARRAY_AW;
   localparam int PW = `PAGE_AW;
   localparam int CW = $clog2(WRITE_CYCLES);
   localparam logic [CW-1:0] PROG_LAST = CW'(WRITE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] line_f;
   logic [3:0] strap_f;
   logic scl_q;
   logic sda_q;

   pin_sync #(.WIDTH(2), .FILT(FILT_CYCLES)) u_line (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pin_i({scl_i, sda_i}),
      .pin_o(line_f)
   );

   // Straps need no filter, only the four-flop chain
   pin_sync #(.WIDTH(4), .FILT(1)) u_strap (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pin_i({select_pin_high_i, select_pin_mid_i, select_pin_low_i, wp_i}),
      .pin_o(strap_f)
   );

   wire scl_f = line_f[1];
   wire sda_f = line_f[0];
   wire wp_f = strap_f[0];
   wire scl_rise = scl_f & ~scl_q;
   wire scl_fall = ~scl_f & scl_q;
   wire start_det = scl_q & scl_f & sda_q & ~sda_f;
   wire stop_det = scl_q & scl_f & ~sda_q & sda_f;

   ////////////////////////////////////////////////////////////////////////
   state_t state_q, state_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] tx_q, tx_d;
   logic oe_q, oe_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [`PAGE_BYTES-1:0] valid_q, valid_d;
   logic pend_q, pend_d;
   logic rdgo_q, rdgo_d;
   logic [CW-1:0] prog_q, prog_d;
   logic cp_we_q;
   logic [PW-1:0] cp_idx_q;
   logic pb_we;
   logic [7:0] arr_rdata;
   logic [7:0] pb_rdata;

   function automatic logic [AW-1:0] page_step(input logic [AW-1:0] a);
      page_step = {a[AW-1:PW], a[PW-1:0] + PW'(1)};
   endfunction : page_step

   // Type code, then select bits high, mid, low; pins default low off-chip
   wire type_hit = shift_q[7:4] == DEV_TYPE;
   wire sel_hit = shift_q[3:1] == strap_f[3:1];
   wire dev_hit = type_hit & sel_hit;
   wire rw_bit = shift_q[0];
   wire ninth = bit_q == `ACK_BIT;
   wire byte_done = scl_fall & ninth;
   wire [2:0] tx_idx = 3'h7 - bit_q[2:0];
   wire tx_bit = (bit_q == 4'h0) ? arr_rdata[7] : tx_q[tx_idx];
   wire in_copy = prog_q < CW'(`PAGE_BYTES);
   wire cp_we_d = (state_q == ST_PROG) & in_copy & valid_q[prog_q[PW-1:0]];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      shift_d = shift_q;
      tx_d = tx_q;
      oe_d = oe_q;
      addr_d = addr_q;
      valid_d = valid_q;
      pend_d = pend_q;
      rdgo_d = rdgo_q;
      prog_d = prog_q;
      pb_we = 1'b0;
      if (state_q == ST_PROG) begin
         // Line deaf until done; address words therefore get no ack
         oe_d = 1'b0;
         prog_d = prog_q + CW'(1);
         if (prog_q == PROG_LAST) begin
            state_d = ST_IDLE;
            prog_d = '0;
            valid_d = '0;
            pend_d = 1'b0;
         end
      end else if (start_det) begin
         state_d = ST_DEV;
         bit_d = 4'h0;
         oe_d = 1'b0;
         rdgo_d = 1'b0;
      end else if (stop_det) begin
         oe_d = 1'b0;
         rdgo_d = 1'b0;
         bit_d = 4'h0;
         state_d = pend_q ? ST_PROG : ST_IDLE;
      end else if (state_q != ST_IDLE) begin
         if (scl_rise) begin
            if (ninth) begin
               bit_d = 4'h0;
               if (state_q == ST_RDATA && sda_f) begin
                  rdgo_d = 1'b0;
               end
            end else begin
               shift_d = {shift_q[6:0], sda_f};
               bit_d = bit_q + 4'h1;
            end
         end
         if (byte_done) begin
            oe_d = 1'b0;
            case (state_q)
               ST_DEV: begin
                  if (dev_hit) begin
                     oe_d = 1'b1;
                     rdgo_d = rw_bit;
                     state_d = rw_bit ? ST_RDATA : ST_ADDR_HI;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
               ST_ADDR_HI: begin
                  oe_d = 1'b1;
                  addr_d = {shift_q[6:0], addr_q[7:0]};
                  state_d = ST_ADDR_LO;
               end
               ST_ADDR_LO: begin
                  oe_d = 1'b1;
                  addr_d = {addr_q[AW-1:8], shift_q};
                  state_d = ST_WDATA;
               end
               ST_WDATA: begin
                  if (wp_f) begin
                     state_d = ST_IDLE;
                  end else begin
                     oe_d = 1'b1;
                     pb_we = 1'b1;
                     valid_d[addr_q[PW-1:0]] = 1'b1;
                     pend_d = 1'b1;
                     addr_d = page_step(addr_q);
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            if (state_q == ST_RDATA && rdgo_q) begin
               oe_d = ~tx_bit;
               if (bit_q == 4'h0) begin
                  tx_d = arr_rdata;
                  addr_d = addr_q + AW'(1);
               end
            end else begin
               oe_d = 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         scl_q <= scl_f;
         sda_q <= sda_f;
         state_q <= state_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         oe_q <= oe_d;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_q <= '0;
         valid_q <= '0;
         pend_q <= 1'b0;
         rdgo_q <= 1'b0;
         prog_q <= '0;
         cp_we_q <= 1'b0;
         cp_idx_q <= '0;
      end else begin
         addr_q <= addr_d;
         valid_q <= valid_d;
         pend_q <= pend_d;
         rdgo_q <= rdgo_d;
         prog_q <= prog_d;
         cp_we_q <= cp_we_d;
         cp_idx_q <= prog_q[PW-1:0];
      end
   end

   // Pin value is always low; only the enable moves
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         prog_busy_o <= 1'b0;
         state_o <= ST_IDLE;
      end else begin
         sda_o <= 1'b0;
         sda_oe_o <= oe_d;
         prog_busy_o <= state_d == ST_PROG;
         state_o <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Page gathered first, copied one byte a cycle during the busy time
   eeprom_mem #(.AW(PW), .DW(`BYTE_W)) u_page (
      .core_clk_i(core_clk_i),
      .we_i(pb_we),
      .waddr_i(addr_q[PW-1:0]),
      .wdata_i(shift_q),
      .raddr_i(prog_q[PW-1:0]),
      .rdata_o(pb_rdata)
   );

   eeprom_mem #(.AW(AW), .DW(`BYTE_W)) u_array (
      .core_clk_i(core_clk_i),
      .we_i(cp_we_q),
      .waddr_i({addr_q[AW-1:PW], cp_idx_q}),
      .wdata_i(pb_rdata),
      .raddr_i(addr_q),
      .rdata_o(arr_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   property p_oe_timing;
      $changed(oe_q) |->
         $past(scl_fall || start_det || stop_det || state_q == ST_PROG);
   endproperty
   a_oe_timing: assert property (p_oe_timing) else $error("sda moved");

   property p_open_drain;
      ##1 !sda_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda high");

   property p_dev_ack;
      byte_done && state_q == ST_DEV && dev_hit |=> sda_oe_o && oe_q;
   endproperty
   a_dev_ack: assert property (p_dev_ack) else $error("own addr nack");

   property p_dev_nack;
      byte_done && state_q == ST_DEV && !dev_hit
         |=> !oe_q && state_q == ST_IDLE;
   endproperty
   a_dev_nack: assert property (p_dev_nack) else $error("foreign acked");

   property p_rw_dir;
      byte_done && state_q == ST_DEV && dev_hit
         |=> state_q == (rw_bit ? ST_RDATA : ST_ADDR_HI);
   endproperty
   a_rw_dir: assert property (p_rw_dir) else $error("wrong direction");

   property p_wp_nack;
      byte_done && state_q == ST_WDATA && wp_f
         |=> !oe_q && state_q == ST_IDLE && valid_q == $past(valid_q);
   endproperty
   a_wp_nack: assert property (p_wp_nack) else $error("protected ack");

   property p_page_wrap;
      byte_done && state_q == ST_WDATA && !wp_f |=>
         addr_q[AW-1:PW] == $past(addr_q[AW-1:PW]) &&
         addr_q[PW-1:0] == $past(addr_q[PW-1:0]) + PW'(1);
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("page step");

   property p_stop_prog;
      stop_det && state_q != ST_PROG && pend_q |=> state_q == ST_PROG ##1
         prog_q == CW'(1);
   endproperty
   a_stop_prog: assert property (p_stop_prog) else $error("no program");

   property p_stop_idle;
      stop_det && state_q != ST_PROG && !pend_q |=> state_q == ST_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("not idle");

   property p_start;
      start_det && state_q != ST_PROG |=> state_q == ST_DEV && bit_q == 4'h0;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_prog_end;
      state_q == ST_PROG && prog_q == PROG_LAST |=> state_q == ST_IDLE;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("prog overran");

   property p_prog_quiet;
      state_q == ST_PROG && $past(state_q == ST_PROG) |-> !oe_q;
   endproperty
   a_prog_quiet: assert property (p_prog_quiet) else $error("busy oe");

   property p_read_halt;
      state_q == ST_RDATA && !rdgo_q && scl_fall |=> !oe_q;
   endproperty
   a_read_halt: assert property (p_read_halt) else $error("read on");

   c_write: cover property (stop_det && pend_q ##1 state_q == ST_PROG);
   c_read_ack: cover property (scl_rise && ninth && rdgo_q && !sda_f);
   c_wp: cover property (byte_done && state_q == ST_WDATA && wp_f);
   c_mismatch: cover property (byte_done && state_q == ST_DEV && !dev_hit);

endmodule : eeprom_slave

`default_nettype wire

// ---- bench/i2c_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module i2c_master_model (
   input wire logic core_clk_i,
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_oe_o
);
   // Low 6, high 2 core cycles: 80 ns period, bus time scaled with core
   // clock; long low phase lets the late synchronised answer settle
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : wait_n

   task automatic bit_x(input logic b, output logic r);
      wait_n(1);
      sda_oe_o = ~b;
      wait_n(5);
      scl_o = 1'b1;
      wait_n(2);
      r = sda_i;
      scl_o = 1'b0;
   endtask : bit_x

   task automatic start_c();
      wait_n(1);
      sda_oe_o = 1'b0;
      wait_n(7);
      scl_o = 1'b1;
      wait_n(4);
      sda_oe_o = 1'b1;
      wait_n(4);
      scl_o = 1'b0;
   endtask : start_c

   task automatic stop_c();
      wait_n(1);
      sda_oe_o = 1'b1;
      wait_n(7);
      scl_o = 1'b1;
      wait_n(4);
      sda_oe_o = 1'b0;
      wait_n(8);
   endtask : stop_c

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, ack);
   endtask : put_byte

   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(nack, r);
   endtask : get_byte
endmodule : i2c_master_model

`default_nettype wire

// ---- bench/test_serial_eeprom_slave_write_path.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_serial_eeprom_slave_write_path;
   import eeprom_pkg::*;
   localparam int WCYC = 200;
   localparam logic [3:0] DTYPE = 4'h5; // Arbitrary type code
   logic core_clk, resetn, m_scl, m_oe, sda_q, dut_oe, busy, wp;
   logic [2:0] sel;
   state_t st;
   wire logic sda_line;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   int busy_cyc = 0;
   logic [7:0] mem [0:32767];

   // Wired AND with pull-up
   assign sda_line = (m_oe | dut_oe) ? 1'b0 : 1'b1;

   i2c_master_model mst (.core_clk_i(core_clk), .sda_i(sda_line),
      .scl_o(m_scl), .sda_oe_o(m_oe));
   // Short bench phases leave no room for the glitch filter's delay
   eeprom_slave #(.DEV_TYPE(DTYPE), .WRITE_CYCLES(WCYC), .FILT_CYCLES(1))
   dut (.core_clk_i(core_clk), .resetn_i(resetn), .scl_i(m_scl),
      .sda_i(sda_line), .select_pin_high_i(sel[2]),
      .select_pin_mid_i(sel[1]), .select_pin_low_i(sel[0]), .wp_i(wp),
      .sda_o(sda_q), .sda_oe_o(dut_oe), .prog_busy_o(busy), .state_o(st));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %0h expected %0h", $time,
            seen, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // Hang guard, well above the expected run
   always @(posedge core_clk) begin
      cyc++;
      if (busy === 1'b1) busy_cyc++;
      if (cyc == 60000) begin
         mismatches++;
         test_done();
      end
   end

   function automatic logic [7:0] devw(input logic rw);
      return {DTYPE, sel, rw};
   endfunction : devw

   task automatic send(input logic [7:0] d, input logic exp_ack);
      logic a;
      mst.put_byte(d, a);
      chk(a, exp_ack);
   endtask : send

   task automatic set_addr(input logic [14:0] a);
      mst.start_c();
      send(devw(1'b0), 1'b0);
      send({1'b0, a[14:8]}, 1'b0);
      send(a[7:0], 1'b0);
   endtask : set_addr

   ////////////////////////////////////////////////////////////////////
   task automatic wr_page(input logic [14:0] a, input int n, input logic p);
      logic [5:0] off;
      logic [7:0] d;
      int k;
      wp = p;
      off = a[5:0];
      set_addr(a);
      for (k = 0; k < n; k++) begin
         d = 8'($urandom);
         send(d, p);
         if (p) break;
         mem[{a[14:6], off}] = d;
         off = off + 6'h01;
      end
      busy_cyc = 0;
      mst.stop_c();
      chk(busy, !p);
      if (!p) begin
         mst.start_c();
         send(devw(1'b0), 1'b1);
         mst.stop_c();
         k = 0;
         while (busy === 1'b1 && k < 3 * WCYC) begin
            @(negedge core_clk);
            k++;
         end
         chk(busy, 1'b0);
         chk(busy_cyc <= WCYC, 1'b1);
         mst.start_c();
         send(devw(1'b0), 1'b0);
         mst.stop_c();
      end
      chk(busy, 1'b0);
      $display("write of %0d bytes done", n);
   endtask : wr_page

   task automatic rd_seq(input logic [14:0] a, input int n);
      logic [7:0] d;
      set_addr(a);
      mst.start_c();
      send(devw(1'b1), 1'b0);
      for (int k = 0; k < n; k++) begin
         mst.get_byte(k == n - 1, d);
         chk(d, mem[a]);
         a = a + 15'h0001;
      end
      mst.stop_c();
      chk(st, ST_IDLE);
      $display("read of %0d bytes done", n);
   endtask : rd_seq

   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [14:0] a;
      logic [7:0] d;
      resetn = 1'b0;
      wp = 1'b0;
      sel = 3'h0;
      foreach (mem[i]) mem[i] = 8'hFF;
      void'($urandom(32'hCA975613));
      repeat (20) @(negedge core_clk);
      sel = 3'($urandom);
      resetn = 1'b1;
      repeat (10) @(negedge core_clk);
      chk({dut_oe, busy}, 2'h0);
      chk(sda_q, 1'b0);
      chk(st, ST_IDLE);
      // Wrong type code, then each select bit flipped
      for (int i = 0; i < 4; i++) begin
         d = devw(1'b0);
         d[7] = (i == 0) ? ~d[7] : d[7];
         d[i] = (i > 0) ? ~d[i] : d[i];
         mst.start_c();
         send(d, 1'b1);
         mst.stop_c();
         chk(st, ST_IDLE);
      end
      $display("address mismatch done");
      a = 15'($urandom);
      wr_page(a, 1, 1'b0);
      rd_seq(a, 1);
      // Start near page end so the offset wraps and overwrites
      a = {a[14:6] + 9'h001, 6'h3E};
      wr_page(a, 66, 1'b0);
      rd_seq({a[14:6], 6'h00}, 66);
      wr_page(a, 1, 1'b1);
      rd_seq(a, 2);
      wp = 1'b0;
      // No zero ack and no stop: line stays released
      set_addr(a);
      mst.start_c();
      send(devw(1'b1), 1'b0);
      mst.get_byte(1'b1, d);
      chk(d, mem[a]);
      mst.get_byte(1'b1, d);
      chk(d, 8'hFF);
      chk({sda_q, dut_oe}, 2'h0);
      mst.stop_c();
      $display("released after nack done");
      rd_seq(15'h7FFF, 2);
      test_done();
   end
endmodule : test_serial_eeprom_slave_write_path

`default_nettype wire
